// ---- rtl/dbgp_defines.vh ----
// Purpose: Constants for the dual byte GPIO block: register map, resets, modes.
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register.
// Notes:   Printed offsets other than fff0 are not multiples of four, so they are register indices.
`ifndef DBGP_DEFINES_VH
`define DBGP_DEFINES_VH

// Register indices as printed; byte address is four times the index.
`define DBGP_IDX_PA_DATA   16'hffd9
`define DBGP_IDX_PB_DATA   16'hffda
`define DBGP_IDX_PA_DIR    16'hffe9
`define DBGP_IDX_PB_DIR    16'hffea
`define DBGP_IDX_MODE      16'hfff0
`define DBGP_IDX_TMR_SEL   16'hfff1
`define DBGP_ADDR_W        18

// Reset values.
`define DBGP_RST_BYTE      8'h00
`define DBGP_RST_MODE      3'h0
`define DBGP_RST_SEL       4'h0

// Port B implemented bits 7 to 3.
`define DBGP_PB_MASK       8'hf8
`define DBGP_DIR_READ      8'hff
`define DBGP_SEL_OFF       4'h0

// Operating modes.
`define DBGP_MODE_ACTIVE   3'h0
`define DBGP_MODE_SUBACT   3'h1
`define DBGP_MODE_SLEEP    3'h2
`define DBGP_MODE_SUBSLP   3'h3
`define DBGP_MODE_STANDBY  3'h4
`define DBGP_MODE_WATCH    3'h5

// Pin positions within port B.
`define DBGP_PB_TMO_BIT    6
`define DBGP_PB_TCLK_BIT   5
`define DBGP_PB_TRST_BIT   4

// AXI responses.
`define DBGP_RESP_OKAY     2'h0
`define DBGP_RESP_SLVERR   2'h2

`endif

// ---- rtl/dbgp_sync.v ----
// Purpose: Two flip-flop synchroniser for a bus of pin levels.
// Assumes: Inputs are asynchronous to sys_clk.
// Notes:   The first stage is read only by the second.
`timescale 1ns/1ps
module dbgp_sync #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         sys_clk,
    input  wire         rst,
    // Data
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] meta_q;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ---- rtl/dbgp_gpio.v ----
// Purpose: Two GPIO ports (A full byte, B bits 7..3) behind an AXI4-Lite slave.
// Assumes: One clock, sys_clk at 20 MHz; pins are sampled through two flops.
// Notes:   Pin drive is qualified by a software-set low-power mode register.
`timescale 1ns/1ps
`include "dbgp_defines.vh"

// Overview of operation
// R1: Port A data register is eight read/write bits, one per pin.
// R2: Port A read gives stored bit for outputs, sampled pin for inputs.
// R3: Port A direction bit 1 makes the pin output, 0 makes it input.
// R4: Port A direction register is write-only and reads all ones.
// R5: Reset clears port A direction, so all pins start as inputs.
// R6: Reset clears port A data register.
// R7: Port A floats in reset, standby, watch; holds in sleeps; works otherwise.
// R8: Port B data bits 2..0 read zero and ignore writes; 7..3 read/write.
// R9: Port B read gives stored bit for outputs, pin level for inputs.
// R10: Port B direction bits 7..3 choose output (1) or input (0).
// R11: Port B direction register is write-only and reads all ones.
// R12: Reset clears both port B registers.
// R13: Nonzero timer select makes port B pin 6 the timer output.
// R14: Port B floats in reset, standby; holds in sleeps and watch; works otherwise.
// R15: Port B pins 5 and 4 feed timer clock and reset when inputs.
// R16: Port B direction writes ignore bits 2..0.
module dbgp_gpio (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // AXI4-Lite write address
    input  wire [31:0] s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [31:0] s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Port A pins
    input  wire [7:0]  port_a_in,
    output reg  [7:0]  port_a_out,
    output reg  [7:0]  port_a_oe,
    // Port B pins, bits 2..0 unused
    input  wire [7:0]  port_b_in,
    output reg  [7:0]  port_b_out,
    output reg  [7:0]  port_b_oe,
    // Timer side
    input  wire        timer_output_pin,
    output reg         timer_clock_input_pin,
    output reg         timer_reset_input_pin
);
    reg  [7:0] port_a_data_q;
    reg  [7:0] port_a_direction_q;
    reg  [7:0] port_b_data_q;
    reg  [7:0] port_b_direction_q;
    reg  [2:0] mode_q;
    reg  [3:0] timer_output_select_q;
    reg        aw_held_q;
    reg        w_held_q;
    reg  [31:0] awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0] wstrb_q;
    wire [7:0] pa_sync;
    wire [7:0] pb_sync;
    wire       tmo_sync;

    reg  [7:0] pa_out_d;
    reg  [7:0] pa_oe_d;
    reg  [7:0] pb_out_d;
    reg  [7:0] pb_oe_d;
    reg  [7:0] pb_func_dir;
    reg  [7:0] pb_func_out;
    reg        wr_fire;
    reg  [31:0] wr_addr;
    reg  [31:0] wr_data;
    reg  [3:0] wr_strb;

    dbgp_sync #(.W(8)) u_sync_a (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (port_a_in),
        .sync_out (pa_sync)
    );

    dbgp_sync #(.W(8)) u_sync_b (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in ({port_b_in[7:1], timer_output_pin}),
        .sync_out ({pb_sync[7:1], tmo_sync})
    );
    assign pb_sync[0] = 1'b0;

    // Word address match: printed index times four, low two bits ignored.
    function hit;
        input [31:0] addr;
        input [15:0] idx;
        begin
            hit = (addr[`DBGP_ADDR_W-1:2] == idx) && (addr[31:`DBGP_ADDR_W] == 14'h0000);
        end
    endfunction

    // Merge stored data with sampled pins by direction.
    function [7:0] mix;
        input [7:0] data;
        input [7:0] dir;
        input [7:0] pins;
        begin
            mix = (data & dir) | (pins & ~dir);
        end
    endfunction

    // Write channel: accept address and data in either order.
    always @* begin
        wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
        wr_data = w_held_q ? wdata_q : s_axi_wdata;
        wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
        wr_fire = (aw_held_q | (s_axi_awvalid & s_axi_awready)) &
                  (w_held_q | (s_axi_wvalid & s_axi_wready)) & ~s_axi_bvalid;
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DBGP_RESP_OKAY;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= 32'h0000_0000;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
        end else begin
            s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
            s_axi_wready  <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                awaddr_q  <= s_axi_awaddr;
                aw_held_q <= 1'b1;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
                w_held_q <= 1'b1;
            end
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (hit(wr_addr, `DBGP_IDX_PA_DATA) |
                                 hit(wr_addr, `DBGP_IDX_PB_DATA) |
                                 hit(wr_addr, `DBGP_IDX_PA_DIR) |
                                 hit(wr_addr, `DBGP_IDX_PB_DIR) |
                                 hit(wr_addr, `DBGP_IDX_MODE) |
                                 hit(wr_addr, `DBGP_IDX_TMR_SEL)) ?
                                `DBGP_RESP_OKAY : `DBGP_RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register stores; only byte lane 0 carries data.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port_a_data_q         <= `DBGP_RST_BYTE; // see R6
            port_a_direction_q    <= `DBGP_RST_BYTE; // see R5
            port_b_data_q         <= `DBGP_RST_BYTE; // see R12
            port_b_direction_q    <= `DBGP_RST_BYTE; // see R12
            mode_q                <= `DBGP_RST_MODE;
            timer_output_select_q <= `DBGP_RST_SEL;
        end else if (wr_fire && wr_strb[0]) begin
            if (hit(wr_addr, `DBGP_IDX_PA_DATA))
                port_a_data_q <= wr_data[7:0]; // see R1
            if (hit(wr_addr, `DBGP_IDX_PA_DIR))
                port_a_direction_q <= wr_data[7:0]; // see R3
            if (hit(wr_addr, `DBGP_IDX_PB_DATA))
                port_b_data_q <= wr_data[7:0] & `DBGP_PB_MASK; // see R8
            if (hit(wr_addr, `DBGP_IDX_PB_DIR))
                port_b_direction_q <= wr_data[7:0] & `DBGP_PB_MASK; // see R10, R16
            if (hit(wr_addr, `DBGP_IDX_MODE))
                mode_q <= wr_data[2:0];
            if (hit(wr_addr, `DBGP_IDX_TMR_SEL))
                timer_output_select_q <= wr_data[3:0];
        end
    end

    // Read channel: one cycle from address to data.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `DBGP_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `DBGP_RESP_OKAY;
                if (hit(s_axi_araddr, `DBGP_IDX_PA_DATA))
                    s_axi_rdata <= {24'h000000,
                        mix(port_a_data_q, port_a_direction_q, pa_sync)}; // see R2
                else if (hit(s_axi_araddr, `DBGP_IDX_PB_DATA))
                    s_axi_rdata <= {24'h000000, mix(port_b_data_q, pb_func_dir,
                        pb_sync) & `DBGP_PB_MASK}; // see R8, R9
                else if (hit(s_axi_araddr, `DBGP_IDX_PA_DIR) |
                         hit(s_axi_araddr, `DBGP_IDX_PB_DIR))
                    s_axi_rdata <= {24'h000000, `DBGP_DIR_READ}; // see R4, R11
                else if (hit(s_axi_araddr, `DBGP_IDX_MODE))
                    s_axi_rdata <= {29'h0, mode_q};
                else if (hit(s_axi_araddr, `DBGP_IDX_TMR_SEL))
                    s_axi_rdata <= {28'h0000000, timer_output_select_q};
                else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `DBGP_RESP_SLVERR;
                end
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Functional pin drive before low-power qualification.
    always @* begin
        pb_func_dir = port_b_direction_q;
        pb_func_out = port_b_data_q;
        if (timer_output_select_q != `DBGP_SEL_OFF) begin
            pb_func_dir[`DBGP_PB_TMO_BIT] = 1'b1; // see R13
            pb_func_out[`DBGP_PB_TMO_BIT] = tmo_sync;
        end
    end

    // Low-power qualification: float, hold, or follow registers.
    always @* begin
        pa_out_d = port_a_out;
        pa_oe_d  = port_a_oe;
        pb_out_d = port_b_out;
        pb_oe_d  = port_b_oe;
        case (mode_q)
            `DBGP_MODE_ACTIVE, `DBGP_MODE_SUBACT: begin
                pa_out_d = port_a_data_q;
                pa_oe_d  = port_a_direction_q; // see R3, R7
                pb_out_d = pb_func_out;
                pb_oe_d  = pb_func_dir; // see R10, R14
            end
            `DBGP_MODE_SLEEP, `DBGP_MODE_SUBSLP: begin
                pa_out_d = port_a_out; // see R7
                pb_out_d = port_b_out; // see R14
            end
            `DBGP_MODE_STANDBY: begin
                pa_oe_d = `DBGP_RST_BYTE; // see R7
                pb_oe_d = `DBGP_RST_BYTE; // see R14
            end
            `DBGP_MODE_WATCH: begin
                pa_oe_d = `DBGP_RST_BYTE; // see R7
                pb_out_d = port_b_out; // see R14
            end
            default: begin
                pa_oe_d = `DBGP_RST_BYTE;
                pb_oe_d = `DBGP_RST_BYTE;
            end
        endcase
    end

    // Outputs float through reset since every enable resets low.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port_a_out            <= `DBGP_RST_BYTE;
            port_a_oe             <= `DBGP_RST_BYTE; // see R7
            port_b_out            <= `DBGP_RST_BYTE;
            port_b_oe             <= `DBGP_RST_BYTE; // see R14
            timer_clock_input_pin <= 1'b0;
            timer_reset_input_pin <= 1'b0;
        end else begin
            port_a_out <= pa_out_d;
            port_a_oe  <= pa_oe_d;
            port_b_out <= pb_out_d & `DBGP_PB_MASK;
            port_b_oe  <= pb_oe_d & `DBGP_PB_MASK;
            // Held at the last value while the pin drives, so the timer sees no edges.
            if (!port_b_direction_q[`DBGP_PB_TCLK_BIT])
                timer_clock_input_pin <= pb_sync[`DBGP_PB_TCLK_BIT]; // see R15
            if (!port_b_direction_q[`DBGP_PB_TRST_BIT])
                timer_reset_input_pin <= pb_sync[`DBGP_PB_TRST_BIT]; // see R15
        end
    end
endmodule

// ---- testbench/dbgp_gpio_sva.sv ----
// Purpose: Bus timing and port B invariants of the dual byte GPIO block.
// Assumes: One clock domain; rst is asynchronous and active high.
// Notes:   The read address is kept so that read data can be judged later.
`timescale 1ns/1ps
`include "dbgp_defines.vh"
module dbgp_gpio_sva (
    // Clock and reset
    input wire        sys_clk,
    input wire        rst,
    // Register bus
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // Port B pins
    input wire [7:0]  port_b_out,
    input wire [7:0]  port_b_oe
);
    localparam [31:0] A_PBD = 32'h4 * `DBGP_IDX_PB_DATA;
    localparam [31:0] A_PAR = 32'h4 * `DBGP_IDX_PA_DIR;
    localparam [31:0] A_PBR = 32'h4 * `DBGP_IDX_PB_DIR;
    reg [31:0] ar_q;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ar_q <= 32'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            ar_q <= s_axi_araddr;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer withdrawn");
    a_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer withdrawn");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("no write answer");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("no read answer");
    a_dir_reads_ones: assert property (
        s_axi_rvalid && (ar_q == A_PAR || ar_q == A_PBR) |-> s_axi_rdata == 32'hff)
        else $error("direction read not all ones");
    a_pb_reserved_zero: assert property (
        s_axi_rvalid && ar_q == A_PBD |-> s_axi_rdata[2:0] == 3'h0)
        else $error("reserved bits read nonzero");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits nonzero");
    a_pb_unused_idle: assert property (
        port_b_oe[2:0] == 3'h0 && port_b_out[2:0] == 3'h0) else $error("unused pin driven");
    c_err: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `DBGP_RESP_SLVERR);
    c_dir: cover property (s_axi_rvalid && ar_q == A_PBR);
    c_drive: cover property (port_b_oe[7:3] == 5'h1f);
endmodule
bind dbgp_gpio dbgp_gpio_sva u_sva (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .port_b_out, .port_b_oe);

// ---- testbench/dbgp_pins_model.sv ----
// Purpose: Board side of both ports: resolves each pin from block and far side.
// Assumes: The far side always drives a level where the block does not.
// Notes:   A released pin shows the far-side pattern, never the last driven value.
`timescale 1ns/1ps
module dbgp_pins_model (
    // Block side
    input  wire [7:0] a_out,
    input  wire [7:0] a_oe,
    input  wire [7:0] b_out,
    input  wire [7:0] b_oe,
    // Far side
    input  wire [7:0] a_ext,
    input  wire [7:0] b_ext,
    // Pin levels
    output wire [7:0] a_in,
    output wire [7:0] b_in
);
    assign a_in = (a_oe & a_out) | (~a_oe & a_ext);
    assign b_in = (b_oe & b_out) | (~b_oe & b_ext);
endmodule

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the dual byte GPIO block.
// Assumes: AXI4-Lite master tasks; pins resolved by the board model.
// Notes:   Settling waits cover two sync flops plus one output register.
`timescale 1ns/1ps
`include "dbgp_defines.vh"
module tb_top;
    localparam [31:0]  A_PAD = 32'h4 * `DBGP_IDX_PA_DATA;
    localparam [31:0]  A_PBD = 32'h4 * `DBGP_IDX_PB_DATA;
    localparam [31:0]  A_PAR = 32'h4 * `DBGP_IDX_PA_DIR;
    localparam [31:0]  A_PBR = 32'h4 * `DBGP_IDX_PB_DIR;
    localparam [31:0]  A_MOD = 32'h4 * `DBGP_IDX_MODE;
    localparam [31:0]  A_SEL = 32'h4 * `DBGP_IDX_TMR_SEL;
    // Per mode: port A oe, port A driven, port B oe, port B driven; mode 0 lowest.
    localparam [191:0] MODE_EXP = {32'h0000f8a8, 32'h0, {2{32'hff55f8a8}}, {2{32'hffaaf850}}};
    reg                sys_clk = 1'b0;
    reg                rst = 1'b1;
    reg  [31:0]        s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    reg                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg  [7:0]         a_ext = 8'h3c, b_ext = 8'hab;
    reg                timer_output_pin = 1'b0;
    wire               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]         s_axi_bresp, s_axi_rresp;
    wire [31:0]        s_axi_rdata;
    wire [7:0]         port_a_in, port_a_out, port_a_oe, port_b_in, port_b_out, port_b_oe;
    wire               timer_clock_input_pin, timer_reset_input_pin;
    integer            n_mismatch = 0, checked = 0, cyc = 0, m;
    reg  [31:0]        rd;
    reg  [1:0]         rs;
    dbgp_gpio dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .port_a_in, .port_a_out, .port_a_oe, .port_b_in, .port_b_out,
        .port_b_oe, .timer_output_pin, .timer_clock_input_pin, .timer_reset_input_pin);
    dbgp_pins_model pins (.a_out(port_a_out), .a_oe(port_a_oe), .b_out(port_b_out),
        .b_oe(port_b_oe), .a_ext(a_ext), .b_ext(b_ext), .a_in(port_a_in), .b_in(port_b_in));
    always #25 sys_clk = ~sys_clk;
    task complete_run;
        begin
            $display("checked %0d mismatches %0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    // A hung handshake would otherwise stall the run forever.
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            complete_run;
        end
    end
    task check(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [31:0] a, input [7:0] d);
        reg ad, wd;
        begin
            ad = 1'b0;
            wd = 1'b0;
            @(posedge sys_clk);
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h0, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            while (!(ad && wd)) begin
                @(posedge sys_clk);
                if (!ad && s_axi_awready === 1'b1) begin
                    ad = 1'b1;
                    s_axi_awvalid <= 1'b0;
                end
                if (!wd && s_axi_wready === 1'b1) begin
                    wd = 1'b1;
                    s_axi_wvalid <= 1'b0;
                end
            end
            // Ready comes a cycle late on purpose, so the slave must hold its answer.
            @(posedge sys_clk);
            s_axi_bready <= 1'b1;
            do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
            rs = s_axi_bresp;
            s_axi_bready <= 1'b0;
        end
    endtask
    task rdr(input [31:0] a);
        begin
            @(posedge sys_clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
            s_axi_arvalid <= 1'b0;
            @(posedge sys_clk);
            s_axi_rready <= 1'b1;
            do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask
    task settle;
        repeat (4) @(posedge sys_clk);
    endtask
    task t_reset_state;
        begin
            rdr(A_PAR);
            check(rd, 32'hff);
            rdr(A_PBR);
            check(rd, 32'hff);
            rdr(A_PAD);
            check(rd, 32'h3c);
            rdr(A_PBD);
            check(rd, 32'ha8);
            wr(A_PAR, 8'hff);
            wr(A_PBR, 8'hff);
            rdr(A_PAD);
            check(rd, 32'h0);
            rdr(A_PBD);
            check(rd, 32'h0);
        end
    endtask
    task t_port_a;
        begin
            wr(A_PAR, 8'h0f);
            wr(A_PAD, 8'ha5);
            check(rs, `DBGP_RESP_OKAY);
            settle;
            check(port_a_oe, 32'h0f);
            check(port_a_out & port_a_oe, 32'h05);
            rdr(A_PAD);
            check(rd, 32'h35);
        end
    endtask
    task t_port_b;
        begin
            wr(A_PBR, 8'hff);
            wr(A_PBD, 8'hff);
            settle;
            check(port_b_oe, 32'hf8);
            rdr(A_PBD);
            check(rd, 32'hf8);
            wr(A_PBR, 8'h00);
            b_ext <= 8'h98;
            settle;
            rdr(A_PBD);
            check(rd, 32'h98);
            check({timer_clock_input_pin, timer_reset_input_pin}, 32'h1);
            b_ext <= 8'h28;
            settle;
            check({timer_clock_input_pin, timer_reset_input_pin}, 32'h2);
        end
    endtask
    task t_timer;
        begin
            wr(A_SEL, 8'h01);
            timer_output_pin <= 1'b1;
            settle;
            check({port_b_oe[6], port_b_out[6]}, 32'h3);
            timer_output_pin <= 1'b0;
            settle;
            check({port_b_oe[6], port_b_out[6]}, 32'h2);
            wr(A_SEL, 8'h00);
            settle;
            check(port_b_oe[6], 32'h0);
        end
    endtask
    task t_modes;
        begin
            wr(A_PAR, 8'hff);
            wr(A_PBR, 8'hff);
            for (m = 0; m < 6; m = m + 1) begin
                wr(A_PAD, 8'h55);
                wr(A_PBD, 8'ha8);
                settle;
                wr(A_MOD, m[7:0]);
                wr(A_PAD, 8'haa);
                wr(A_PBD, 8'h50);
                settle;
                check({port_a_oe, port_a_out & port_a_oe, port_b_oe, port_b_out & port_b_oe},
                      MODE_EXP[m*32 +: 32]);
                rdr(A_PAD);
                check(rd, 32'haa);
                wr(A_MOD, `DBGP_MODE_ACTIVE);
            end
        end
    endtask
    task t_unmapped;
        begin
            wr(32'h100, 8'h12);
            check(rs, `DBGP_RESP_SLVERR);
            rdr(32'h100);
            check(rs, `DBGP_RESP_SLVERR);
            check(rd, 32'h0);
        end
    endtask
    initial begin
        repeat (15) @(posedge sys_clk);
        check({port_a_oe, port_b_oe}, 32'h0);
        @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t_reset_state;
        t_port_a;
        t_port_b;
        t_timer;
        t_modes;
        t_unmapped;
        complete_run;
    end
endmodule
